/* File: verilog/ccd_defines.vh */
// Purpose: Constants for the channel cycle decoder.
// Assumes: Select and status inputs are bus pins, synchronised before use.
// Notes: Status inputs are taken as sampled levels, 1 = pin high.
// How it works
// - Select/A/B: 001 IO write, 010 IO read, 101 mem write, 110 mem read, rest reserved.
// - On an I/O write the slave captures data the master holds through the strobe.
// - On an I/O read the slave drives data after the strobe starts until it ends.
// - On a memory write the slave captures data the master holds through the strobe.
// - On a memory read the slave drives data after the strobe starts until it ends.
// - High-byte enable with address bit 0 picks lane D8-D15 or D0-D7 on 16-bit slaves.
// - The DMA terminal-count pulse within a command marks the last cycle of a block.
// - Width-translate inactive: master drives byte enables 0-3; active: translator does.
// - Select high means a memory cycle, low means an I/O cycle.
// - The slave latches status on the strobe leading edge or decode latch trailing edge.
`ifndef CCD_DEFINES_VH
`define CCD_DEFINES_VH
`define CCD_CMD_NONE 3'h0
`define CCD_CMD_IOW 3'h1
`define CCD_CMD_IOR 3'h2
`define CCD_CMD_MEMW 3'h5
`define CCD_CMD_MEMR 3'h6
`define CCD_CODE_IOW 3'h1
`define CCD_CODE_IOR 3'h2
`define CCD_CODE_MEMW 3'h5
`define CCD_CODE_MEMR 3'h6
`define CCD_LATCH_CMD 1'h0
`define CCD_LATCH_ADL 1'h1
`define CCD_CTRL_IDLE 4'h3
`define CCD_MARK_IDLE 2'h3
`define CCD_LANE_NONE 2'h0
`define CCD_DATA_RST 16'h0000
`endif

/* File: verilog/ccd_channel_cycle_decode.v */
// Purpose: Slave-side cycle decode and data phase control for a 16-bit channel.
// Assumes: All channel pins are asynchronous and pass two flops first.
// Notes: Active-low pins arrive as raw pin levels with _n names.
`timescale 1ns/1ps
`include "ccd_defines.vh"
module ccd_channel_cycle_decode #(
    parameter LATCH_SEL = 1'h0
) (
    input wire mclk,
    input wire arst_n,
    input wire mem_io_sel,
    input wire status_line_a,
    input wire status_line_b,
    input wire cmd_n,
    input wire adl_n,
    input wire addr_match,
    input wire addr0,
    input wire high_byte_enable_n,
    input wire terminal_count_pulse_n,
    input wire width_translate_select,
    input wire [15:0] data_in,
    input wire [15:0] rd_data,
    output wire [15:0] data_out,
    output wire [1:0] data_oe,
    output wire [15:0] wr_data,
    output wire [1:0] wr_lanes,
    output wire wr_strobe,
    output wire rd_strobe,
    output wire [2:0] cycle_cmd,
    output wire is_memory,
    output wire last_dma,
    output wire translator_owns_be
);
    // Two-flop synchronisers for every pin
    reg [15:0] s1_q;
    reg [15:0] s2_q;
    reg [1:0] a1_q;
    reg [1:0] a2_q;
    reg [3:0] c1_q;
    reg [3:0] c2_q;
    reg cmd_prev_q;
    reg adl_prev_q;
    reg [2:0] lat_q;
    reg [1:0] lane_q;
    reg tc_q;
    reg rd_done_q;
    reg [15:0] data_out_q;
    reg [1:0] data_oe_q;
    reg [15:0] wr_data_q;
    reg [1:0] wr_lanes_q;
    reg wr_strobe_q;
    reg rd_strobe_q;
    reg [2:0] cycle_cmd_q;
    reg is_memory_q;
    reg last_dma_q;
    reg translator_owns_be_q;
    wire cmd_act = ~c2_q[0];
    wire adl_act = ~c2_q[1];
    wire cmd_lead = cmd_act & ~cmd_prev_q;
    wire cmd_trail = ~cmd_act & cmd_prev_q;
    wire adl_trail = ~adl_act & adl_prev_q;
    wire [2:0] live = {a2_q[0], c2_q[2], c2_q[3]};
    wire latch_now = (LATCH_SEL == `CCD_LATCH_ADL) ? adl_trail : cmd_lead;

    function [2:0] decode;
        input [2:0] code;
        begin
            case (code)
                `CCD_CODE_IOW: decode = `CCD_CMD_IOW;
                `CCD_CODE_IOR: decode = `CCD_CMD_IOR;
                `CCD_CODE_MEMW: decode = `CCD_CMD_MEMW;
                `CCD_CODE_MEMR: decode = `CCD_CMD_MEMR;
                default: decode = `CCD_CMD_NONE;
            endcase
        end
    endfunction

    // lane choice: bit 0 low lane, bit 1 high lane
    function [1:0] lanes;
        input a0;
        input bhe_n;
        begin
            lanes = {~bhe_n, ~a0};
        end
    endfunction

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 16'h0000;
            s2_q <= 16'h0000;
            a1_q <= 2'h0;
            a2_q <= 2'h0;
            c1_q <= `CCD_CTRL_IDLE;
            c2_q <= `CCD_CTRL_IDLE;
        end else begin
            s1_q <= data_in;
            s2_q <= s1_q;
            a1_q <= {addr_match, mem_io_sel};
            a2_q <= a1_q;
            c1_q <= {status_line_b, status_line_a, adl_n, cmd_n};
            c2_q <= c1_q;
        end
    end

    reg [1:0] x1_q;
    reg [1:0] x2_q;
    reg [1:0] y1_q;
    reg [1:0] y2_q;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            x1_q <= `CCD_MARK_IDLE;
            x2_q <= `CCD_MARK_IDLE;
            y1_q <= 2'h0;
            y2_q <= 2'h0;
        end else begin
            x1_q <= {terminal_count_pulse_n, high_byte_enable_n};
            x2_q <= x1_q;
            y1_q <= {width_translate_select, addr0};
            y2_q <= y1_q;
        end
    end

    wire [2:0] cmd_d = decode(live);
    wire lat_read = (lat_q == `CCD_CMD_IOR) || (lat_q == `CCD_CMD_MEMR);
    wire lat_write = (lat_q == `CCD_CMD_IOW) || (lat_q == `CCD_CMD_MEMW);

    assign data_out = data_out_q;
    assign data_oe = data_oe_q;
    assign wr_data = wr_data_q;
    assign wr_lanes = wr_lanes_q;
    assign wr_strobe = wr_strobe_q;
    assign rd_strobe = rd_strobe_q;
    assign cycle_cmd = cycle_cmd_q;
    assign is_memory = is_memory_q;
    assign last_dma = last_dma_q;
    assign translator_owns_be = translator_owns_be_q;

    // Edge trackers reset to idle, so no false edge follows reset
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_prev_q <= 1'h0;
            adl_prev_q <= 1'h0;
        end else begin
            cmd_prev_q <= cmd_act;
            adl_prev_q <= adl_act;
        end
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            translator_owns_be_q <= 1'h0;
        end else begin
            translator_owns_be_q <= y2_q[1];
        end
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lat_q <= `CCD_CMD_NONE;
            lane_q <= `CCD_LANE_NONE;
            cycle_cmd_q <= `CCD_CMD_NONE;
            is_memory_q <= 1'h0;
        end else begin
            if (latch_now) begin
                // Miss or reserved code keeps the slave off the bus
                lat_q <= a2_q[1] ? cmd_d : `CCD_CMD_NONE;
                lane_q <= lanes(y2_q[0], x2_q[0]);
                cycle_cmd_q <= a2_q[1] ? cmd_d : `CCD_CMD_NONE;
                is_memory_q <= a2_q[0];
            end else if (cmd_trail) begin
                lat_q <= `CCD_CMD_NONE;
            end
        end
    end

    // terminal count seen, pulse wins over clear
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tc_q <= 1'h0;
            last_dma_q <= 1'h0;
        end else begin
            if (cmd_act && !x2_q[1]) begin
                tc_q <= 1'h1;
            end else if (cmd_lead) begin
                tc_q <= 1'h0;
            end
            if (cmd_trail) begin
                last_dma_q <= tc_q;
            end
        end
    end

    // drive during strobe, one take per strobe
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            data_out_q <= `CCD_DATA_RST;
            data_oe_q <= `CCD_LANE_NONE;
            rd_strobe_q <= 1'h0;
            rd_done_q <= 1'h0;
        end else begin
            rd_strobe_q <= 1'h0;
            if (cmd_act && lat_read) begin
                // Flag, not the enables, blocks a repeat take on an empty lane set
                if (!rd_done_q) begin
                    rd_strobe_q <= 1'h1;
                    data_out_q <= rd_data;
                    rd_done_q <= 1'h1;
                end
                data_oe_q <= lane_q;
            end else begin
                data_oe_q <= `CCD_LANE_NONE;
                rd_done_q <= 1'h0;
            end
        end
    end

    // capture during strobe, pulse after it ends
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_data_q <= `CCD_DATA_RST;
            wr_lanes_q <= `CCD_LANE_NONE;
            wr_strobe_q <= 1'h0;
        end else begin
            wr_strobe_q <= 1'h0;
            if (cmd_act && lat_write) begin
                wr_data_q <= s2_q;
                wr_lanes_q <= lane_q;
            end
            if (cmd_trail && lat_write) begin
                wr_strobe_q <= 1'h1;
            end
        end
    end
endmodule

/* File: test/ccd_master_model.sv */
// Purpose: Channel master, one cycle per call
// Assumes: Status idles at a reserved code
// Notes: Released data shows its inverse
`timescale 1ns/1ps
module ccd_mst (
    input wire logic clk,
    output logic [8:0] p = 9'h0f3,
    output logic [15:0] d = 16'h0
);
    task cyc(input [2:0] c, input [3:0] f, input [15:0] v, input [3:0] n);
        @(posedge clk) #1 p[3:0] = f;
        d = v;
        @(posedge clk) #1 p[8:6] = c;
        @(posedge clk) #1 p[4] = 1'h0;
        @(posedge clk) #1 p[4] = 1'h1;
        @(posedge clk) #1 p[5] = 1'h0;
        repeat (n) @(posedge clk);
        #1 p[5] = 1'h1;
        repeat (4) @(posedge clk);
        #1 p = 9'h0f3;
        d = ~v;
    endtask
endmodule

/* File: test/ccd_channel_cycle_decode_assertions.sv */
// Purpose: Port checks
// Assumes: Top ports only
// Notes: Reset disables all
`timescale 1ns/1ps
module ccd_chk (
    input wire mclk,
    input wire arst_n,
    input wire cmd_n,
    input wire width_translate_select,
    input wire rd_strobe,
    input wire wr_strobe,
    input wire is_memory,
    input wire translator_owns_be,
    input wire [1:0] data_oe,
    input wire [2:0] cycle_cmd
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence idle5; cmd_n [*5]; endsequence
    sequence busy4; !cmd_n [*4] ##0 |data_oe; endsequence
    code_legal_a: assert property (cycle_cmd inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6})
        else $error("bad code");
    rd_drive_a: assert property (|data_oe |-> cycle_cmd inside {3'h2, 3'h6})
        else $error("drive off read");
    rd_take_a: assert property (rd_strobe |-> cycle_cmd inside {3'h2, 3'h6})
        else $error("take off read");
    mem_flag_a: assert property (cycle_cmd != 3'h0 |-> is_memory == cycle_cmd[2])
        else $error("space flag");
    wr_pulse_a: assert property (wr_strobe |=> !wr_strobe)
        else $error("long write pulse");
    rd_pulse_a: assert property (rd_strobe |=> !rd_strobe)
        else $error("long read pulse");
    oe_drop_a: assert property (idle5 |-> data_oe == 2'h0)
        else $error("drive after strobe");
    oe_hold_a: assert property (busy4 |=> |data_oe)
        else $error("drive dropped");
    xlate_follow_a: assert property ($changed(width_translate_select) |->
        ##[1:4] translator_owns_be == width_translate_select) else $error("owner lag");
endmodule
bind ccd_channel_cycle_decode ccd_chk chk_i (.mclk(mclk), .arst_n(arst_n), .cmd_n(cmd_n),
    .width_translate_select(width_translate_select), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .is_memory(is_memory), .translator_owns_be(translator_owns_be),
    .data_oe(data_oe), .cycle_cmd(cycle_cmd));

/* File: test/testbench.sv */
// Purpose: Cycle decode bench
// Assumes: Both latch edges, one instance each
// Notes: dut strobes matched to a queue, dut_adl strobes checked against lf
`timescale 1ns/1ps
module testbench;
    logic mclk = 0, arst_n = 0, xl = 0, ws, rs, im, ld, tob;
    logic [8:0] p;
    logic [15:0] d, rd = 16'h0, dout, wd, lf = 16'h18;
    logic [1:0] oe, wl;
    logic [2:0] cc;
    logic [22:0] q[$], e;
    int n_mismatch = 0, num_checks = 0;
    logic ws2, rs2;
    logic [15:0] dout2, wd2;
    logic [2:0] cc2;
    int n_adl = 0;
    always #50 mclk = ~mclk;
    ccd_mst mm (.clk(mclk), .p(p), .d(d));
    ccd_channel_cycle_decode dut (.mclk(mclk), .arst_n(arst_n), .mem_io_sel(p[8]),
        .status_line_a(p[7]), .status_line_b(p[6]), .cmd_n(p[5]), .adl_n(p[4]),
        .addr_match(p[3]), .addr0(p[2]), .high_byte_enable_n(p[1]),
        .terminal_count_pulse_n(p[0]), .width_translate_select(xl), .data_in(d),
        .rd_data(rd), .data_out(dout), .data_oe(oe), .wr_data(wd), .wr_lanes(wl),
        .wr_strobe(ws), .rd_strobe(rs), .cycle_cmd(cc), .is_memory(im),
        .last_dma(ld), .translator_owns_be(tob));
    ccd_channel_cycle_decode #(.LATCH_SEL(1'h1)) dut_adl (.mclk(mclk), .arst_n(arst_n),
        .mem_io_sel(p[8]), .status_line_a(p[7]), .status_line_b(p[6]), .cmd_n(p[5]),
        .adl_n(p[4]), .addr_match(p[3]), .addr0(p[2]), .high_byte_enable_n(p[1]),
        .terminal_count_pulse_n(p[0]), .width_translate_select(xl), .data_in(d),
        .rd_data(rd), .data_out(dout2), .data_oe(), .wr_data(wd2), .wr_lanes(),
        .wr_strobe(ws2), .rd_strobe(rs2), .cycle_cmd(cc2), .is_memory(), .last_dma(),
        .translator_owns_be());
    function automatic [15:0] nxt(input [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chk(input logic [15:0] s, x);
        num_checks++;
        if (s !== x) begin
            n_mismatch++;
            $display("FAIL %0t got %h want %h", $time, s, x);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(negedge mclk) if (rs || ws) begin
        chk(q.size() > 0, 16'h1);
        e = q.pop_front();
        chk(rs, e[22]);
        chk(rs ? dout : wd, e[21:6]);
        chk(rs ? oe : wl, e[5:4]);
        if (rs) chk(cc, e[2:0]);
        else chk(im, e[2]);
        if (ws) begin
            repeat (2) @(negedge mclk);
            chk(ld, e[3]);
        end
    end
    always @(negedge mclk) if (rs2 || ws2) begin
        n_adl++;
        if (rs2) chk(dout2, ~lf);
        else chk(wd2, lf);
    end
    task go(input [2:0] c, input f);
        logic [15:0] r;
        logic a, b, m, k, w;
        r = lf;
        a = r[3];
        b = r[3] ? 1'h0 : r[4];
        m = f | r[5] | r[6];
        k = c == 3'h2 || c == 3'h6;
        w = m && (k || c == 3'h1 || c == 3'h5);
        rd = ~r;
        xl = r[11];
        n_adl = 0;
        if (w) q.push_back({k, k ? ~r : r, ~b, ~a, ~r[7], c});
        mm.cyc(c, {m, a, b, r[7]}, r, 4'h2 + r[10:8]);
        chk(tob, xl);
        chk(cc, w ? c : 3'h0);
        chk(cc2, w ? c : 3'h0);
        chk(n_adl, w);
        lf = nxt(lf);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        #1 arst_n = 1;
        repeat (3) @(posedge mclk);
        #1;
        for (int i = 0; i < 48; i++) begin
            go(i < 8 ? i[2:0] : lf[2:0], i < 8);
            $display("test %0d done", i);
        end
        chk(q.size(), 16'h0);
        tally_and_finish;
    end
    initial begin
        #600000;
        n_mismatch++;
        tally_and_finish;
    end
endmodule
